// ### design/dpsm_defs.vh
// Constants for the direction plausibility safety monitor.
`ifndef DPSM_DEFS_VH
`define DPSM_DEFS_VH
`define DPSM_SPEED_W         16
`define DPSM_SPEED_LIMIT_RST 16'h0064
`define DPSM_RAMP_TIME_US    100000
`define DPSM_CLK_MHZ         10
`define DPSM_RAMP_CYCLES     (`DPSM_RAMP_TIME_US * `DPSM_CLK_MHZ)
`define DPSM_LOSS_TIME_US    1000
`define DPSM_LOSS_CYCLES     (`DPSM_LOSS_TIME_US * `DPSM_CLK_MHZ)
`define DPSM_MOT_STILL       2'h0
`define DPSM_MOT_FWD         2'h1
`define DPSM_MOT_BWD         2'h2
`endif

// ### design/dpsm_top.v
// Direction plausibility safety monitor for a linear positioning axis.
// How it works
// - Backward motion with only backward test active keeps torque outputs on.
// - Any other pattern during backward motion latches the safe state.
// - Safe state during motion drops both torque-off outputs.
// - Safe state holds until cause gone, then reset, then separate restart.
// - Limited-speed request low with speed over limit starts a hold stop.
// - After a limited-speed stop, motion resumes only on restart command.
// - Emergency stop ramps the drive down, then removes torque.
// - Optional brake engages at standstill in the ramp-down or the safe state; reset also sets it.
// - Releasing emergency stop alone never restarts motion.
// - Losing position sensor 1 is a fault and drops the stop-request output.
// - Losing position sensor 2 is a fault and drops the stop-request output.
// - Losing the motion-monitor link is a fault and drops stop-request.
// - Losing the sensor-identifier 1 input is a fault and drops stop-request.
// - Forward motion needs only forward test active; else safe state.
// - At standstill both test signals active; else stop-request drops.
`timescale 1ns/1ps
`default_nettype none
`include "dpsm_defs.vh"
module dpsm_top #(
	parameter integer RAMP_CYCLES  = `DPSM_RAMP_CYCLES,
	parameter integer LOSS_CYCLES  = `DPSM_LOSS_CYCLES,
	parameter         BRAKE_USED   = 1'b1
) (
	input  wire                      clk_i,
	input  wire                      reset_n_i,
	input  wire                      forward_test_in_i,
	input  wire                      backward_test_in_i,
	input  wire [1:0]                motion_state_i,
	input  wire [`DPSM_SPEED_W-1:0]  speed_i,
	input  wire [`DPSM_SPEED_W-1:0]  speed_limit_i,
	input  wire                      standstill_i,
	input  wire                      limited_speed_request_n_i,
	input  wire                      estop_n_i,
	input  wire                      sensor1_alive_i,
	input  wire                      sensor2_alive_i,
	input  wire                      monitor_alive_i,
	input  wire                      sensor_id1_alive_i,
	input  wire                      fault_reset_i,
	input  wire                      restart_i,
	output wire                      torque_off_out_a_o,
	output wire                      torque_off_out_b_o,
	output wire                      stop_request_out_o,
	output wire                      ramp_down_o,
	output wire                      brake_o,
	output wire                      hold_stop_o,
	output wire                      fault_o
);
	localparam [4:0] ST_RUN   = 5'h01;
	localparam [4:0] ST_HOLD  = 5'h02;
	localparam [4:0] ST_RAMP  = 5'h04;
	localparam [4:0] ST_SAFE  = 5'h08;
	localparam [4:0] ST_ARMED = 5'h10;
	localparam integer NSYNC = 9;

	reg        rst_a_ff;
	reg        rst_b_ff;
	wire       rst_n = rst_b_ff;

	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_a_ff <= 1'b0;
			rst_b_ff <= 1'b0;
		end else begin
			rst_a_ff <= 1'b1;
			rst_b_ff <= rst_a_ff;
		end
	end

	// Every pin input passes two flip-flops before use.
	wire [NSYNC-1:0] raw = {restart_i, fault_reset_i, sensor_id1_alive_i, monitor_alive_i,
		sensor2_alive_i, sensor1_alive_i, estop_n_i, limited_speed_request_n_i, standstill_i};
	reg  [NSYNC-1:0] s1_ff;
	reg  [NSYNC-1:0] s2_ff;
	reg  [3:0]       t1_ff;
	reg  [3:0]       t2_ff;
	reg  [`DPSM_SPEED_W-1:0] sp1_ff;
	reg  [`DPSM_SPEED_W-1:0] sp2_ff;
	reg  [`DPSM_SPEED_W-1:0] lm1_ff;
	reg  [`DPSM_SPEED_W-1:0] lm2_ff;

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff  <= {NSYNC{1'b0}};
			s2_ff  <= {NSYNC{1'b0}};
			t1_ff  <= 4'h0;
			t2_ff  <= 4'h0;
			sp1_ff <= {`DPSM_SPEED_W{1'b0}};
			sp2_ff <= {`DPSM_SPEED_W{1'b0}};
			lm1_ff <= `DPSM_SPEED_LIMIT_RST;
			lm2_ff <= `DPSM_SPEED_LIMIT_RST;
		end else begin
			s1_ff  <= raw;
			s2_ff  <= s1_ff;
			t1_ff  <= {forward_test_in_i, backward_test_in_i, motion_state_i};
			t2_ff  <= t1_ff;
			sp1_ff <= speed_i;
			sp2_ff <= sp1_ff;
			lm1_ff <= speed_limit_i;
			lm2_ff <= lm1_ff;
		end
	end

	wire still    = s2_ff[0];
	wire lsr_on   = ~s2_ff[1];
	wire estop_on = ~s2_ff[2];
	wire rst_cmd  = s2_ff[7];
	wire rs_cmd   = s2_ff[8];
	wire fwd      = t2_ff[3];
	wire bwd      = t2_ff[2];
	wire [1:0] mot = t2_ff[1:0];

	// Short dropouts are filtered; a link dead for the loss time is a fault.
	wire [3:0] loss_hit;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_loss
			reg [31:0] cnt_ff;
			always @(posedge clk_i or negedge rst_n) begin
				if (!rst_n) begin
					cnt_ff <= 32'h0000_0000;
				end else if (s2_ff[3+g]) begin
					cnt_ff <= 32'h0000_0000;
				end else if (cnt_ff < LOSS_CYCLES) begin
					cnt_ff <= cnt_ff + 32'h0000_0001;
				end
			end
			assign loss_hit[g] = (cnt_ff >= LOSS_CYCLES);
		end
	endgenerate

	reg plaus_bad;
	always @* begin
		case (mot)
			`DPSM_MOT_BWD: plaus_bad = ~(~fwd & bwd);
			`DPSM_MOT_FWD: plaus_bad = ~(fwd & ~bwd);
			`DPSM_MOT_STILL: plaus_bad = ~(fwd & bwd);
			default: plaus_bad = 1'b1;
		endcase
	end

	wire fault_now = plaus_bad | (|loss_hit);

	reg [4:0]  st_ff;
	reg [4:0]  nxt_st;
	reg [31:0] ramp_ff;
	reg [31:0] nxt_ramp;
	reg        brake_ff;
	reg        nxt_brake;

	always @* begin
		nxt_st    = st_ff;
		nxt_ramp  = ramp_ff;
		nxt_brake = brake_ff;
		case (st_ff)
			ST_RUN: begin
				nxt_brake = 1'b0;
				if (fault_now) begin
					nxt_st = ST_SAFE;
				end else if (estop_on) begin
					nxt_st   = ST_RAMP;
					nxt_ramp = 32'h0000_0000;
				end else if (lsr_on && (sp2_ff > lm2_ff)) begin
					nxt_st = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (fault_now) begin
					nxt_st = ST_SAFE;
				end else if (estop_on) begin
					nxt_st   = ST_RAMP;
					nxt_ramp = 32'h0000_0000;
				end else if (rs_cmd && !lsr_on) begin
					nxt_st = ST_RUN;
				end
			end
			ST_RAMP: begin
				if (ramp_ff < RAMP_CYCLES) begin
					nxt_ramp = ramp_ff + 32'h0000_0001;
				end
				if (still && BRAKE_USED) begin
					nxt_brake = 1'b1;
				end
				if (still || ramp_ff >= RAMP_CYCLES) begin
					nxt_st = ST_SAFE;
				end
			end
			ST_SAFE: begin
				if (BRAKE_USED && still) begin
					nxt_brake = 1'b1;
				end
				if (rst_cmd && !fault_now && !estop_on) begin
					nxt_st = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (fault_now || estop_on) begin
					nxt_st = ST_SAFE;
				end else if (rs_cmd && !rst_cmd) begin
					nxt_st = ST_RUN;
				end
			end
			default: nxt_st = ST_SAFE;
		endcase
	end

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_ff    <= ST_SAFE;
			ramp_ff  <= 32'h0000_0000;
			brake_ff <= 1'b1;
		end else begin
			st_ff    <= nxt_st;
			ramp_ff  <= nxt_ramp;
			brake_ff <= nxt_brake;
		end
	end

	// Torque stays on during the hold and ramp stops; the safe and armed states cut it.
	// Two separate flops keep the redundant torque outputs from sharing one failure point.
	wire nxt_torque = (nxt_st == ST_RUN) || (nxt_st == ST_HOLD) || (nxt_st == ST_RAMP);
	reg  torque_a_ff;
	reg  torque_b_ff;
	reg  stopreq_ff;
	reg  fault_ff;
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			torque_a_ff <= 1'b0;
			torque_b_ff <= 1'b0;
			stopreq_ff  <= 1'b0;
			fault_ff    <= 1'b1;
		end else begin
			torque_a_ff <= nxt_torque;
			torque_b_ff <= nxt_torque;
			stopreq_ff  <= (nxt_st == ST_RUN) || (nxt_st == ST_HOLD);
			fault_ff    <= (nxt_st == ST_SAFE) || (nxt_st == ST_ARMED);
		end
	end

	assign torque_off_out_a_o = torque_a_ff;
	assign torque_off_out_b_o = torque_b_ff;
	assign stop_request_out_o = stopreq_ff;
	assign ramp_down_o        = (st_ff == ST_RAMP);
	assign hold_stop_o        = (st_ff == ST_HOLD);
	assign brake_o            = brake_ff;
	assign fault_o            = fault_ff;
endmodule
`default_nettype wire

// ### tb/dpsm_axis_model.sv
// Axis model that reaches standstill a few cycles into a ramp-down and stays there.
`timescale 1ns/1ps
`default_nettype none
module dpsm_axis_model (
	input  wire logic clk_i,
	input  wire logic ramp_i,
	input  wire logic torque_i,
	input  wire logic still_i,
	output var  logic standstill_o
);
	logic [2:0] n_ff = 3'h0;
	// With torque cut the axis cannot move, so standstill holds until torque returns.
	always @(posedge clk_i) n_ff <= ramp_i ? n_ff + {2'h0, n_ff != 3'h7} : (torque_i ? 3'h0 : n_ff);
	// A real axis needs time to brake, so standstill never follows the ramp at once.
	assign standstill_o = still_i | (n_ff > 3'h3);
endmodule
`default_nettype wire

// ### tb/dpsm_monitor.sv
// Checker bound to the monitor top.
`timescale 1ns/1ps
`default_nettype none
module dpsm_monitor (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic standstill_i,
	input wire logic estop_n_i,
	input wire logic restart_i,
	input wire logic torque_off_out_a_o,
	input wire logic torque_off_out_b_o,
	input wire logic stop_request_out_o,
	input wire logic ramp_down_o,
	input wire logic brake_o,
	input wire logic hold_stop_o,
	input wire logic fault_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_run;
		torque_off_out_a_o && !fault_o;
	endsequence
	property p_pair; torque_off_out_a_o == torque_off_out_b_o; endproperty
	a_pair: assert property (p_pair) else $error("torque outputs differ");
	property p_fstop; fault_o |-> !stop_request_out_o; endproperty
	a_fstop: assert property (p_fstop) else $error("stop request on in fault");
	property p_ftrq; fault_o |-> !torque_off_out_a_o; endproperty
	a_ftrq: assert property (p_ftrq) else $error("torque on in fault");
	property p_rst;
		$rose(torque_off_out_a_o) |-> $past(restart_i, 2) || $past(restart_i, 3);
	endproperty
	a_rst: assert property (p_rst) else $error("torque without restart");
	property p_estop; $fell(estop_n_i) ##0 s_run |-> ##[1:4] ramp_down_o; endproperty
	a_estop: assert property (p_estop) else $error("no ramp on estop");
	property p_ramp; ramp_down_o |-> torque_off_out_a_o; endproperty
	a_ramp: assert property (p_ramp) else $error("torque cut during ramp");
	property p_brake;
		$rose(brake_o) |-> $past(standstill_i, 2) || $past(standstill_i, 3);
	endproperty
	a_brake: assert property (p_brake) else $error("brake before standstill");
	property p_hold; hold_stop_o |-> s_run ##0 stop_request_out_o; endproperty
	a_hold: assert property (p_hold) else $error("hold stop cut torque");
endmodule
bind dpsm_top dpsm_monitor mon (.*);
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the direction plausibility safety monitor.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_i = 1'b0, reset_n_i = 1'b0, forward_test_in_i = 1'b1, backward_test_in_i = 1'b1;
	logic limited_speed_request_n_i = 1'b1, estop_n_i = 1'b1, fault_reset_i = 1'b0;
	logic restart_i = 1'b0, standstill_i, torque_off_out_a_o, torque_off_out_b_o;
	logic sensor1_alive_i, sensor2_alive_i, monitor_alive_i, sensor_id1_alive_i;
	logic stop_request_out_o, ramp_down_o, brake_o, hold_stop_o, fault_o;
	logic [1:0] motion_state_i = 2'h0;
	logic [3:0] lnk = 4'hf;
	logic [15:0] speed_i = 16'h0000, speed_limit_i = 16'h0064;
	int n_mismatch = 0, checked = 0;
	// Rows hold motion, forward test, backward test and whether the pattern is plausible.
	logic [4:0] rows [12] = '{5'h07, 5'h02, 5'h04, 5'h00, 5'h0d, 5'h0e,
		5'h0a, 5'h08, 5'h13, 5'h16, 5'h14, 5'h10};
	assign {sensor1_alive_i, sensor2_alive_i, monitor_alive_i, sensor_id1_alive_i} = lnk;
	always #50 clk_i = ~clk_i;
	dpsm_top #(.RAMP_CYCLES(20), .LOSS_CYCLES(5)) dut (
		.clk_i                     (clk_i),
		.reset_n_i                 (reset_n_i),
		.forward_test_in_i         (forward_test_in_i),
		.backward_test_in_i        (backward_test_in_i),
		.motion_state_i            (motion_state_i),
		.speed_i                   (speed_i),
		.speed_limit_i             (speed_limit_i),
		.standstill_i              (standstill_i),
		.limited_speed_request_n_i (limited_speed_request_n_i),
		.estop_n_i                 (estop_n_i),
		.sensor1_alive_i           (sensor1_alive_i),
		.sensor2_alive_i           (sensor2_alive_i),
		.monitor_alive_i           (monitor_alive_i),
		.sensor_id1_alive_i        (sensor_id1_alive_i),
		.fault_reset_i             (fault_reset_i),
		.restart_i                 (restart_i),
		.torque_off_out_a_o        (torque_off_out_a_o),
		.torque_off_out_b_o        (torque_off_out_b_o),
		.stop_request_out_o        (stop_request_out_o),
		.ramp_down_o               (ramp_down_o),
		.brake_o                   (brake_o),
		.hold_stop_o               (hold_stop_o),
		.fault_o                   (fault_o)
	);
	dpsm_axis_model axis (
		.clk_i        (clk_i),
		.ramp_i       (ramp_down_o),
		.torque_i     (torque_off_out_a_o),
		.still_i      (motion_state_i == 2'h0),
		.standstill_o (standstill_i)
	);
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#10;
	endtask
	task automatic chk(input logic s, input logic e);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h, expected %h", $time, s, e);
		end
	endtask
	task automatic pulse_restart;
		restart_i = 1'b1;
		cyc(4);
		restart_i = 1'b0;
		cyc(1);
	endtask
	task automatic arm(input logic [1:0] m);
		motion_state_i = m;
		forward_test_in_i = (m != 2'h2);
		backward_test_in_i = (m != 2'h1);
		cyc(4);
		fault_reset_i = 1'b1;
		cyc(4);
		fault_reset_i = 1'b0;
		pulse_restart;
		cyc(3);
		chk(torque_off_out_b_o, 1'b1);
	endtask
	task automatic finish_test;
		$display("checks %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		cyc(8);
		chk(stop_request_out_o, 1'b0);
		reset_n_i = 1'b1;
		for (int i = 0; i < 12; i++) begin
			arm(rows[i][4:3]);
			{forward_test_in_i, backward_test_in_i} = rows[i][2:1];
			cyc(5);
			chk(torque_off_out_a_o, rows[i][0]);
			chk(stop_request_out_o, rows[i][0]);
			pulse_restart;
			chk(fault_o, !rows[i][0]);
		end
		arm(2'h1);
		speed_i = 16'h0064;
		limited_speed_request_n_i = 1'b0;
		cyc(5);
		chk(hold_stop_o, 1'b0);
		speed_i = 16'h0065;
		cyc(5);
		chk(hold_stop_o, 1'b1);
		limited_speed_request_n_i = 1'b1;
		cyc(5);
		chk(hold_stop_o, 1'b1);
		pulse_restart;
		chk(hold_stop_o, 1'b0);
		estop_n_i = 1'b0;
		cyc(4);
		chk(ramp_down_o, 1'b1);
		chk(brake_o, 1'b0);
		cyc(16);
		chk(torque_off_out_a_o, 1'b0);
		chk(brake_o, 1'b1);
		estop_n_i = 1'b1;
		cyc(8);
		chk(torque_off_out_b_o, 1'b0);
		for (int i = 0; i < 4; i++) begin
			arm(2'h0);
			lnk[i] = 1'b0;
			cyc(12);
			chk(stop_request_out_o, 1'b0);
			lnk[i] = 1'b1;
			cyc(4);
			chk(fault_o, 1'b1);
		end
		// A reset in mid-run from the running state must drop everything to safe values.
		arm(2'h0);
		reset_n_i = 1'b0;
		cyc(2);
		chk(torque_off_out_a_o, 1'b0);
		chk(torque_off_out_b_o, 1'b0);
		chk(stop_request_out_o, 1'b0);
		chk(brake_o, 1'b1);
		chk(fault_o, 1'b1);
		reset_n_i = 1'b1;
		cyc(8);
		chk(fault_o, 1'b1);
		chk(torque_off_out_a_o, 1'b0);
		arm(2'h0);
		chk(fault_o, 1'b0);
		finish_test;
	end
endmodule
`default_nettype wire
